// *** src/peer_update_scheduler.sv ***
/*
  Peer update scheduler: AXI4-Lite registers, period timer, change detection
  and a per-channel update stream with valid/ready.
  Assumes chan_in comes from pins in another domain; upd_ready is on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module peer_update_scheduler #(
  parameter int CYCLES_PER_UNIT = peer_update_pkg::CYCLES_PER_UNIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [peer_update_pkg::NUM_CH-1:0][peer_update_pkg::CH_W-1:0] chan_in,
  output logic upd_valid,
  output peer_update_pkg::update_s upd,
  input wire logic upd_ready,
  output logic irq
);

  localparam int N = peer_update_pkg::NUM_CH;
  localparam int W = peer_update_pkg::CH_W;
  localparam logic [31:0] UNIT_LAST = 32'(CYCLES_PER_UNIT - 1);
  localparam logic [peer_update_pkg::IDX_W-1:0] LAST_CH = 3'(N - 1);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    peer_update_pkg::mode_e mode;
    logic cos_en;
    logic gl;
    logic [15:0] period;
    logic [6:0] dev;
    logic [N-1:0] mask;
    logic [N-1:0] digital;
    logic [31:0] sdest;
    logic [peer_update_pkg::IRQ_W-1:0] irq_st;
    logic [peer_update_pkg::IRQ_W-1:0] irq_mask;
    logic [peer_update_pkg::IDX_W-1:0] tbl_idx;
    logic [31:0] tbl_addr;
    logic [N-1:0][W-1:0] sync1;
    logic [N-1:0][W-1:0] sync2;
    logic [31:0] unit_cnt;
    logic [15:0] per_cnt;
    logic pend_per;
    peer_update_pkg::sched_e st;
    logic [peer_update_pkg::IDX_W-1:0] ch;
    logic [N-1:0][W-1:0] snap;
    logic [N-1:0][W-1:0] last;
    logic [N-1:0] chg;
    logic cosf;
    logic upd_valid;
    peer_update_pkg::update_s upd;
    logic irq;
  } state_s;

  state_s s_reg;
  state_s s_next;
  peer_update_pkg::target_s tbl_rd;
  peer_update_pkg::target_s tbl_wd;
  logic tbl_we;
  logic wr_do;
  logic unit_tick;
  logic per_tick;
  logic cos_live;
  logic [N-1:0] chg_live;
  logic [N-1:0] chg_seen;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] reg_word(input state_s s, input logic [11:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      peer_update_pkg::OFS_CTRL: begin
        r[peer_update_pkg::CTRL_EN_BIT] = s.en;
        r[peer_update_pkg::CTRL_MODE_BIT] = s.mode;
        r[peer_update_pkg::CTRL_COS_BIT] = s.cos_en;
        r[peer_update_pkg::CTRL_GL_BIT] = s.gl;
      end
      peer_update_pkg::OFS_STATUS: r = {24'h000000, s.chg};
      peer_update_pkg::OFS_PERIOD: r = {16'h0000, s.period};
      peer_update_pkg::OFS_DEVIATION: r = {25'h0, s.dev};
      peer_update_pkg::OFS_CH_MASK: r = {24'h000000, s.mask};
      peer_update_pkg::OFS_DIGITAL: r = {24'h000000, s.digital};
      peer_update_pkg::OFS_SINGLE_DEST: r = s.sdest;
      peer_update_pkg::OFS_IRQ_STATUS: r = {29'h0, s.irq_st};
      peer_update_pkg::OFS_IRQ_MASK: r = {29'h0, s.irq_mask};
      peer_update_pkg::OFS_TBL_INDEX: r = {29'h0, s.tbl_idx};
      peer_update_pkg::OFS_TBL_ADDR: r = s.tbl_addr;
      default: r = '0;
    endcase
    return r;
  endfunction : reg_word

  function automatic logic mapped(input logic [11:0] a);
    return (a[1:0] == 2'h0) && (a <= peer_update_pkg::OFS_TBL_CHAN);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel change detection against the last value sent
  generate
    for (genvar g = 0; g < N; g++) begin : g_chg
      logic [W-1:0] diff;
      logic [23:0] lhs;
      logic [23:0] rhs;
      assign diff = (s_reg.sync2[g] > s_reg.last[g]) ? s_reg.sync2[g] - s_reg.last[g]
                                                      : s_reg.last[g] - s_reg.sync2[g];
      assign lhs = 24'(diff) * peer_update_pkg::PCT_SCALE;
      assign rhs = 24'(s_reg.dev) * peer_update_pkg::FULL_RANGE;
      assign chg_live[g] = s_reg.digital[g] ? (s_reg.sync2[g][0] ^ s_reg.last[g][0])
                                            : (lhs > rhs);
    end
  endgenerate

  assign chg_seen = chg_live &
                    ((s_reg.mode == peer_update_pkg::SINGLE_TARGET_MODE) ? s_reg.mask : '1);
  assign cos_live = s_reg.en && s_reg.cos_en && |chg_seen;
  assign unit_tick = s_reg.en && (s_reg.unit_cnt == UNIT_LAST);
  assign per_tick = unit_tick && (s_reg.per_cnt + 16'h0001 >= s_reg.period);
  assign wr_do = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign tbl_we = wr_do && (s_reg.awaddr == peer_update_pkg::OFS_TBL_CHAN);
  assign tbl_wd = '{en: s_reg.wdata[peer_update_pkg::TBL_EN_BIT], addr: s_reg.tbl_addr,
                    chan: s_reg.wdata[7:0]};

  target_table u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(tbl_we),
    .waddr(s_reg.tbl_idx),
    .wdata(tbl_wd),
    .raddr(s_reg.ch),
    .rdata(tbl_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [31:0] wv;
    logic [peer_update_pkg::IRQ_W-1:0] ev;
    logic rd_clr;
    logic next_ch;
    wv = '0;
    ev = '0;
    rd_clr = 1'b0;
    next_ch = 1'b0;
    s_next = s_reg;
    s_next.sync1 = chan_in;
    s_next.sync2 = s_reg.sync1;
    // Bus write channel
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_do) begin
      wv = merge(reg_word(s_reg, s_reg.awaddr), s_reg.wdata, s_reg.wstrb);
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.awaddr) ? peer_update_pkg::RESP_OKAY
                                          : peer_update_pkg::RESP_SLVERR;
      unique case (s_reg.awaddr)
        peer_update_pkg::OFS_CTRL: begin
          s_next.mode = peer_update_pkg::mode_e'(wv[peer_update_pkg::CTRL_MODE_BIT]);
          s_next.cos_en = wv[peer_update_pkg::CTRL_COS_BIT];
          s_next.en = wv[peer_update_pkg::CTRL_EN_BIT];
          s_next.gl = wv[peer_update_pkg::CTRL_GL_BIT];
          if (wv[peer_update_pkg::CTRL_EN_BIT] &&
              (wv[peer_update_pkg::CTRL_GL_BIT] || s_reg.gl)) begin
            ev[peer_update_pkg::IRQ_REFUSED] = 1'b1;
            s_next.en = !s_reg.gl;
            s_next.gl = s_reg.gl;
          end
        end
        peer_update_pkg::OFS_PERIOD: s_next.period = wv[15:0];
        peer_update_pkg::OFS_DEVIATION: s_next.dev = wv[6:0];
        peer_update_pkg::OFS_CH_MASK: s_next.mask = wv[N-1:0];
        peer_update_pkg::OFS_DIGITAL: s_next.digital = wv[N-1:0];
        peer_update_pkg::OFS_SINGLE_DEST: s_next.sdest = wv;
        peer_update_pkg::OFS_IRQ_MASK: s_next.irq_mask = wv[peer_update_pkg::IRQ_W-1:0];
        peer_update_pkg::OFS_TBL_INDEX: s_next.tbl_idx = wv[peer_update_pkg::IDX_W-1:0];
        peer_update_pkg::OFS_TBL_ADDR: s_next.tbl_addr = wv;
        default: begin
        end
      endcase
    end
    // Bus read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = reg_word(s_reg, s_axi_araddr);
      s_next.rresp = mapped(s_axi_araddr) ? peer_update_pkg::RESP_OKAY
                                          : peer_update_pkg::RESP_SLVERR;
      rd_clr = (s_axi_araddr == peer_update_pkg::OFS_IRQ_STATUS);
    end
    // Period timer, never touched by change-triggered frames
    if (!s_reg.en) begin
      s_next.unit_cnt = '0;
      s_next.per_cnt = '0;
    end else if (unit_tick) begin
      s_next.unit_cnt = '0;
      s_next.per_cnt = per_tick ? 16'h0000 : s_reg.per_cnt + 16'h0001;
    end else begin
      s_next.unit_cnt = s_reg.unit_cnt + 32'h00000001;
    end
    if (per_tick) begin
      s_next.pend_per = 1'b1;
    end
    // Update scheduler
    unique case (s_reg.st)
      peer_update_pkg::ST_IDLE: begin
        if (s_reg.en && (s_reg.pend_per || per_tick || cos_live)) begin
          s_next.st = peer_update_pkg::ST_SCAN;
          s_next.pend_per = 1'b0;
          s_next.ch = '0;
          s_next.snap = s_reg.sync2;
          s_next.chg = chg_seen;
          s_next.cosf = cos_live;
          ev[peer_update_pkg::IRQ_COS] = cos_live;
        end
      end
      peer_update_pkg::ST_SCAN: begin
        if (!s_reg.en) begin
          s_next.st = peer_update_pkg::ST_IDLE;
        end else if (s_reg.mode == peer_update_pkg::MULTIPLE_TARGET_MODE) begin
          s_next.st = peer_update_pkg::ST_LOOKUP;
        end else if (s_reg.mask[s_reg.ch]) begin
          s_next.st = peer_update_pkg::ST_EMIT;
          s_next.upd_valid = 1'b1;
          s_next.upd = '{dest_addr: s_reg.sdest, dest_chan: 8'(s_reg.ch),
                         src_chan: s_reg.ch, value: s_reg.snap[s_reg.ch],
                         changed: s_reg.chg, cos: s_reg.cosf};
        end else begin
          next_ch = 1'b1;
        end
      end
      peer_update_pkg::ST_LOOKUP: begin
        if (!s_reg.en) begin
          s_next.st = peer_update_pkg::ST_IDLE;
        end else if (tbl_rd.en) begin
          s_next.st = peer_update_pkg::ST_EMIT;
          s_next.upd_valid = 1'b1;
          s_next.upd = '{dest_addr: tbl_rd.addr, dest_chan: tbl_rd.chan,
                         src_chan: s_reg.ch, value: s_reg.snap[s_reg.ch],
                         changed: s_reg.chg, cos: s_reg.cosf};
        end else begin
          next_ch = 1'b1;
        end
      end
      peer_update_pkg::ST_EMIT: begin
        if (upd_ready) begin
          s_next.upd_valid = 1'b0;
          s_next.last[s_reg.ch] = s_reg.snap[s_reg.ch];
          next_ch = 1'b1;
        end
      end
    endcase
    if (next_ch) begin
      if (s_reg.ch == LAST_CH) begin
        s_next.st = peer_update_pkg::ST_IDLE;
        ev[peer_update_pkg::IRQ_SENT] = 1'b1;
      end else begin
        s_next.st = peer_update_pkg::ST_SCAN;
        s_next.ch = s_reg.ch + 3'h1;
      end
    end
    // Sticky events, set wins over read clear
    s_next.irq_st = (rd_clr ? '0 : s_reg.irq_st) | ev;
    s_next.irq = |(s_next.irq_st & s_next.irq_mask);
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready = !s_next.w_held && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
    if (!aresetn) begin
      s_next = '0;
      s_next.period = peer_update_pkg::PERIOD_RESET;
      s_next.dev = peer_update_pkg::DEV_RESET;
      s_next.mask = peer_update_pkg::MASK_RESET;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_reg <= s_next;
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign upd_valid = s_reg.upd_valid;
  assign upd = s_reg.upd;
  assign irq = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_off;
    $rose(aresetn) |-> !s_reg.en && !upd_valid && s_reg.mask == peer_update_pkg::MASK_RESET;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("not off after reset");
  property p_exclusive;
    !(s_reg.en && s_reg.gl);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("both functions on");
  property p_refuse;
    wr_do && s_reg.awaddr == peer_update_pkg::OFS_CTRL && s_reg.gl &&
      s_reg.wdata[peer_update_pkg::CTRL_EN_BIT] && s_reg.wstrb[0]
      |=> !s_reg.en && s_reg.irq_st[peer_update_pkg::IRQ_REFUSED];
  endproperty
  a_refuse: assert property (p_refuse) else $error("enable not refused");
  property p_single_dest;
    upd_valid && s_reg.mode == peer_update_pkg::SINGLE_TARGET_MODE
      |-> upd.dest_addr == s_reg.sdest && upd.dest_chan == 8'(upd.src_chan)
          && s_reg.mask[upd.src_chan];
  endproperty
  a_single_dest: assert property (p_single_dest) else $error("bad single update");
  property p_multi_skip;
    s_reg.st == peer_update_pkg::ST_LOOKUP && s_reg.en && !tbl_rd.en |=> !upd_valid;
  endproperty
  a_multi_skip: assert property (p_multi_skip) else $error("unmapped channel sent");
  property p_period;
    per_tick && s_reg.st == peer_update_pkg::ST_IDLE |=> s_reg.st == peer_update_pkg::ST_SCAN;
  endproperty
  a_period: assert property (p_period) else $error("period missed");
  property p_cos;
    cos_live && s_reg.st == peer_update_pkg::ST_IDLE |=> s_reg.st == peer_update_pkg::ST_SCAN
      ##0 s_reg.cosf;
  endproperty
  a_cos: assert property (p_cos) else $error("change not sent at once");
  property p_changed;
    upd_valid |-> upd.changed == s_reg.chg && upd.cos == s_reg.cosf;
  endproperty
  a_changed: assert property (p_changed) else $error("change set wrong");
  property p_timer_kept;
    s_reg.st == peer_update_pkg::ST_IDLE && cos_live && !unit_tick
      |=> s_reg.per_cnt == $past(s_reg.per_cnt);
  endproperty
  a_timer_kept: assert property (p_timer_kept) else $error("timer disturbed");
  property p_hold;
    upd_valid && !upd_ready |=> upd_valid && $stable(upd);
  endproperty
  a_hold: assert property (p_hold) else $error("update dropped before ready");

  c_single: cover property (upd_valid && upd_ready && upd.cos &&
                            s_reg.mode == peer_update_pkg::SINGLE_TARGET_MODE);
  c_multi: cover property (upd_valid && upd_ready &&
                           s_reg.mode == peer_update_pkg::MULTIPLE_TARGET_MODE);
  c_refused: cover property ($rose(s_reg.irq_st[peer_update_pkg::IRQ_REFUSED]));
  c_irq: cover property ($rose(irq));

endmodule : peer_update_scheduler
`default_nettype wire

// *** src/peer_update_pkg.sv ***
/*
  Constants, register map and carrier types of the peer update scheduler.
  Assumes a single 50 MHz clock and a 12-bit AXI4-Lite byte address.
*/
package peer_update_pkg;

  localparam int NUM_CH = 8;
  localparam int CH_W = 16;
  localparam int IDX_W = 3;
  localparam int AXI_AW = 12;

  localparam logic [AXI_AW-1:0] OFS_CTRL = 12'h000;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 12'h004;
  localparam logic [AXI_AW-1:0] OFS_PERIOD = 12'h008;
  localparam logic [AXI_AW-1:0] OFS_DEVIATION = 12'h00C;
  localparam logic [AXI_AW-1:0] OFS_CH_MASK = 12'h010;
  localparam logic [AXI_AW-1:0] OFS_DIGITAL = 12'h014;
  localparam logic [AXI_AW-1:0] OFS_SINGLE_DEST = 12'h018;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STATUS = 12'h01C;
  localparam logic [AXI_AW-1:0] OFS_IRQ_MASK = 12'h020;
  localparam logic [AXI_AW-1:0] OFS_TBL_INDEX = 12'h024;
  localparam logic [AXI_AW-1:0] OFS_TBL_ADDR = 12'h028;
  localparam logic [AXI_AW-1:0] OFS_TBL_CHAN = 12'h02C;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_COS_BIT = 2;
  localparam int CTRL_GL_BIT = 3;
  localparam int TBL_EN_BIT = 8;

  localparam int IRQ_W = 3;
  localparam int IRQ_REFUSED = 0;
  localparam int IRQ_SENT = 1;
  localparam int IRQ_COS = 2;

  localparam logic [15:0] PERIOD_RESET = 16'h03E8;
  localparam logic [6:0] DEV_RESET = 7'h05;
  localparam logic [NUM_CH-1:0] MASK_RESET = 8'hFF;
  localparam logic [23:0] FULL_RANGE = 24'h00FFFF;
  localparam logic [23:0] PCT_SCALE = 24'h000064;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_HZ = 50_000_000;
  localparam int PERIOD_UNIT_MS = 1;
  localparam int CYCLES_PER_UNIT = CLK_HZ / 1000 * PERIOD_UNIT_MS;

  typedef enum logic {SINGLE_TARGET_MODE, MULTIPLE_TARGET_MODE} mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_LOOKUP, ST_EMIT} sched_e;

  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [7:0] chan;
  } target_s;

  typedef struct packed {
    logic [31:0] dest_addr;
    logic [7:0] dest_chan;
    logic [IDX_W-1:0] src_chan;
    logic [CH_W-1:0] value;
    logic [NUM_CH-1:0] changed;
    logic cos;
  } update_s;

endpackage : peer_update_pkg

// *** src/target_table.sv ***
/*
  Per-channel destination table for multiple target mode.
  Assumes one write port and one read port on the same clock; read data is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module target_table (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [peer_update_pkg::IDX_W-1:0] waddr,
  input wire peer_update_pkg::target_s wdata,
  input wire logic [peer_update_pkg::IDX_W-1:0] raddr,
  output peer_update_pkg::target_s rdata
);

  typedef struct packed {
    peer_update_pkg::target_s [peer_update_pkg::NUM_CH-1:0] mem;
    peer_update_pkg::target_s rd;
  } tbl_s;

  tbl_s s_reg;
  tbl_s s_next;

  always_comb begin
    s_next = s_reg;
    if (we) begin
      s_next.mem[waddr] = wdata;
    end
    s_next.rd = s_reg.mem[raddr];
    if (!aresetn) begin
      s_next = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_reg <= s_next;
  end

  assign rdata = s_reg.rd;

endmodule : target_table
`default_nettype wire

// *** tb/upd_sink.sv ***
/*
  Update stream sink in place of the remote receiver.
  Assumes the scheduler holds each item until taken; slow makes ready toggle.
*/
`timescale 1ns/1ps
`default_nettype none
module upd_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  output logic upd_ready
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_ready <= 1'b0;
    end else begin
      upd_ready <= slow ? ~upd_ready : 1'b1;
    end
  end
endmodule : upd_sink
`default_nettype wire

// *** tb/tb_top.sv ***
/*
  Self-checking bench of the peer update scheduler.
  Assumes the package, the scheduler and the update sink are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [1:0] r;} row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic slow = 1'b0;
  logic [peer_update_pkg::NUM_CH-1:0][peer_update_pkg::CH_W-1:0] chan_in = '0;
  logic awready, wready, bvalid, arready, rvalid, upd_valid, upd_ready, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  peer_update_pkg::update_s upd;
  peer_update_pkg::update_s got[$];
  int stamp[$];
  int cyc = 0;
  int failures = 0;
  int n_compared = 0;
  row_s rows [5];
  ////////////////////////////////////////
  peer_update_scheduler #(.CYCLES_PER_UNIT(10)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chan_in(chan_in), .upd_valid(upd_valid), .upd(upd), .upd_ready(upd_ready), .irq(irq));
  upd_sink sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .upd_ready(upd_ready));
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (upd_valid === 1'b1 && upd_ready === 1'b1) begin
      got.push_back(upd);
      stamp.push_back(cyc);
    end
    if (cyc == 8000) begin
      failures++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
  endtask : rd
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc
  task automatic tally_and_finish();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    rows[0] = '{peer_update_pkg::OFS_CTRL, 32'h0, peer_update_pkg::RESP_OKAY};
    rows[1] = '{peer_update_pkg::OFS_PERIOD, 32'h3E8, peer_update_pkg::RESP_OKAY};
    rows[2] = '{peer_update_pkg::OFS_DEVIATION, 32'h5, peer_update_pkg::RESP_OKAY};
    rows[3] = '{peer_update_pkg::OFS_CH_MASK, 32'hFF, peer_update_pkg::RESP_OKAY};
    rows[4] = '{12'h100, 32'h0, peer_update_pkg::RESP_SLVERR};
    for (int i = 0; i < 8; i++) chan_in[i] <= 16'h2222 * 16'(i);
    wait_cyc(8);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      check("reset value", d, rows[i].d);
      check("read resp", resp, rows[i].r);
    end
    wait_cyc(60);
    check("takes while off", got.size(), 0);
    wr(12'h100, 32'h0);
    check("bad write resp", resp, peer_update_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(peer_update_pkg::OFS_CTRL, 32'h8);
    wr(peer_update_pkg::OFS_IRQ_MASK, 32'h1);
    wr(peer_update_pkg::OFS_CTRL, 32'h9);
    rd(peer_update_pkg::OFS_CTRL, d);
    check("ctrl after refusal", d, 32'h8);
    wr(peer_update_pkg::OFS_CTRL, 32'h1);
    check("ctrl write resp", resp, peer_update_pkg::RESP_OKAY);
    rd(peer_update_pkg::OFS_CTRL, d);
    check("enable while gl on", d, 32'h8);
    wait_cyc(2);
    check("irq raised", irq, 1'b1);
    rd(peer_update_pkg::OFS_IRQ_STATUS, d);
    check("irq status", d, 32'h1);
    wait_cyc(2);
    check("irq cleared", irq, 1'b0);
    wr(peer_update_pkg::OFS_CTRL, 32'h0);
    $display("test refusal done");
    wr(peer_update_pkg::OFS_PERIOD, 32'h2);
    wr(peer_update_pkg::OFS_CH_MASK, 32'h0F);
    wr(peer_update_pkg::OFS_SINGLE_DEST, 32'h0A0B0C0D);
    wr(peer_update_pkg::OFS_CTRL, 32'h1);
    got.delete();
    stamp.delete();
    wait_cyc(50);
    wr(peer_update_pkg::OFS_CTRL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      check("single src", got[i].src_chan, i % 4);
      check("single dest", got[i].dest_addr, 32'h0A0B0C0D);
      check("single chan", got[i].dest_chan, i % 4);
      check("single value", got[i].value, chan_in[i % 4]);
    end
    check("period", stamp[4] - stamp[0], 20);
    check("masked irq", irq, 1'b0);
    $display("test single done");
    wr(peer_update_pkg::OFS_PERIOD, 32'hFFFF);
    wr(peer_update_pkg::OFS_DIGITAL, 32'hFF);
    wr(peer_update_pkg::OFS_CTRL, 32'h5);
    slow <= 1'b1;
    wait_cyc(40);
    got.delete();
    chan_in[1][0] <= ~chan_in[1][0];
    wait_cyc(60);
    check("cos count", got.size(), 4);
    check("cos flag", got[0].cos, 1'b1);
    check("changed set", got[3].changed, 8'h02);
    wr(peer_update_pkg::OFS_DIGITAL, 32'h0);
    got.delete();
    chan_in[2] <= chan_in[2] + 16'h0CCC;
    wait_cyc(40);
    check("small move", got.size(), 0);
    chan_in[2] <= chan_in[2] + 16'h0001;
    wait_cyc(40);
    check("large move", got[0].changed, 8'h04);
    $display("test change done");
    wr(peer_update_pkg::OFS_CTRL, 32'h0);
    wr(peer_update_pkg::OFS_DIGITAL, 32'hFF);
    wr(peer_update_pkg::OFS_TBL_INDEX, 32'h2);
    wr(peer_update_pkg::OFS_TBL_ADDR, 32'hC0A80105);
    wr(peer_update_pkg::OFS_TBL_CHAN, 32'h105);
    wr(peer_update_pkg::OFS_CTRL, 32'h7);
    wait_cyc(40);
    got.delete();
    chan_in[2][0] <= ~chan_in[2][0];
    wait_cyc(60);
    check("multi count", got.size(), 1);
    check("multi dest", got[0].dest_addr, 32'hC0A80105);
    check("multi chan", got[0].dest_chan, 8'h05);
    check("multi src", got[0].src_chan, 3'h2);
    $display("test multiple done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
